//--- logic/button_debounce.v
// Push-button synchroniser and de-bouncer with press and release pulses
module button_debounce (
  input  wire clk,
  input  wire reset_n,
  input  wire soft_reset,
  input  wire push_button_input,
  output reg  pressed,
  output reg  press_pulse,
  output reg  release_pulse
);
`include "wakeup_osc_defs.vh"

  reg                   sync_a;
  reg                   sync_b;
  reg [`DEB_WIDTH-1:0]  count;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a        <= 1'b0;
      sync_b        <= 1'b0;
      count         <= {`DEB_WIDTH{1'b0}};
      pressed       <= 1'b0;
      press_pulse   <= 1'b0;
      release_pulse <= 1'b0;
    end else begin
      sync_a        <= push_button_input;
      sync_b        <= sync_a;
      press_pulse   <= 1'b0;
      release_pulse <= 1'b0;
      if (soft_reset) begin
        count   <= {`DEB_WIDTH{1'b0}};
        pressed <= 1'b0;
      end else if (sync_b == pressed) begin
        count <= {`DEB_WIDTH{1'b0}};
      end else if (count == `DEB_CYCLES - 16'h0001) begin // R3
        count         <= {`DEB_WIDTH{1'b0}};
        pressed       <= sync_b;
        press_pulse   <= sync_b;
        release_pulse <= ~sync_b;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end
endmodule // button_debounce

//--- logic/wakeup_osc_defs.vh
// Constants for the wake-up, oscillator and reset controller
`ifndef WAKEUP_OSC_DEFS_VH
`define WAKEUP_OSC_DEFS_VH

`define CMD_WIDTH        16
`define CMD_SW_RESET     16'hFE00
`define CMD_PLL_MASK     16'hFF00
`define CMD_PLL_CODE     16'hC200
`define PLL_MODE_BIT     1
`define RESET_TIME_MS    150
`define CLK_HZ           50000000
`define RESET_CYCLES     (`RESET_TIME_MS * (`CLK_HZ / 1000))
`define DEB_CYCLES       16'h0400
`define DEB_WIDTH        16
`define OSC_IDLE         2'h0
`define OSC_RUN          2'h1
`define OSC_WAIT_ACK     2'h2
`define EV_WIDTH         3
`define EV_POR           3'h0
`define EV_PB_PRESS      3'h1
`define EV_TIMER         3'h2
`define EV_LOW_SUPPLY    3'h3
`define EV_PB_RELEASE    3'h4
`define EV_STATUS_READ   3'h5
`define QUEUE_DEPTH      4
`define QPTR_WIDTH       2
`define QCNT_WIDTH       3

`endif

//--- logic/wakeup_osc_reset_control.v
// Wake-up event sequencer, oscillator gating and reset-mode control
// How it works
// R1 - Command bit 1 set in the PLL command selects normal reset mode.
// R2 - Host sends FE00h; device then enters software reset.
// R3 - Oscillator clock sequences events and de-bounces the push-button.
// R4 - Stopped oscillator starts for an event, then stops again.
// R5 - Starters: power-on, press, timer, low supply, release, status read.
// R6 - Two wake-ups in a row keep oscillator on until status read.
// R7 - Software reset acts exactly like power-on reset; code leaves queue entries and input synchronisers uncleared on it.
// R8 - Any reset restores sensitive mode and clears all control state.
// R9 - Commands ignored during reset; reset lasts up to 150 ms.
// R10 - Pending wake-ups queue in order; status read clears the oldest.
`include "wakeup_osc_defs.vh"
module wakeup_osc_reset_control (
  input  wire                  clk,
  input  wire                  reset_n,
  input  wire                  cmd_valid,
  input  wire [`CMD_WIDTH-1:0] cmd_word,
  input  wire                  status_read,
  input  wire                  push_button_input,
  input  wire                  timer_expired,
  input  wire                  low_supply,
  output wire                  cmd_ready,
  output reg                   osc_enable,
  output reg                   sensitive_reset,
  output reg                   in_reset,
  output reg                   event_pending,
  output reg  [`EV_WIDTH-1:0]  event_code,
  output reg                   status_ack
);

  parameter RESET_COUNT = `RESET_CYCLES;

  // ---------------------------------------------
  // Input synchronisers
  // ---------------------------------------------
  reg timer_a, timer_b, timer_c;
  reg low_a, low_b, low_c;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_a <= 1'b0;
      timer_b <= 1'b0;
      timer_c <= 1'b0;
      low_a   <= 1'b0;
      low_b   <= 1'b0;
      low_c   <= 1'b0;
    end else begin
      timer_a <= timer_expired;
      timer_b <= timer_a;
      timer_c <= timer_b;
      low_a   <= low_supply;
      low_b   <= low_a;
      low_c   <= low_b;
    end
  end

  wire timer_rise = timer_b & ~timer_c;
  wire low_rise   = low_b & ~low_c;

  // ---------------------------------------------
  // Reset sequencing
  // ---------------------------------------------
  reg [31:0] reset_count;
  reg        por_event;
  wire       sw_reset_cmd;

  assign cmd_ready    = ~in_reset; // R9
  assign sw_reset_cmd = cmd_valid & ~in_reset &
                        (cmd_word == `CMD_SW_RESET); // R2

  // Software reset reloads the same counter as power-on
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_reset    <= 1'b1;
      reset_count <= 32'h0000_0000;
      por_event   <= 1'b0;
    end else begin
      por_event <= 1'b0;
      if (sw_reset_cmd) begin // R7
        in_reset    <= 1'b1;
        reset_count <= 32'h0000_0000;
      end else if (in_reset) begin // R9
        if (reset_count >= RESET_COUNT - 1) begin
          in_reset  <= 1'b0;
          por_event <= 1'b1;
        end else begin
          reset_count <= reset_count + 32'h0000_0001;
        end
      end
    end
  end

  // ---------------------------------------------
  // Reset-mode selection
  // ---------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sensitive_reset <= 1'b1;
    end else if (sw_reset_cmd) begin
      sensitive_reset <= 1'b1; // R8
    end else if (cmd_valid && !in_reset &&
                 (cmd_word & `CMD_PLL_MASK) == `CMD_PLL_CODE &&
                 cmd_word[`PLL_MODE_BIT]) begin
      sensitive_reset <= 1'b0; // R1
    end
  end

  // ---------------------------------------------
  // Push-button de-bouncing
  // ---------------------------------------------
  wire pb_pressed;
  wire pb_press;
  wire pb_release;

  button_debounce u_debounce (
    .clk               (clk),
    .reset_n           (reset_n),
    .soft_reset        (in_reset),
    .push_button_input (push_button_input),
    .pressed           (pb_pressed),
    .press_pulse       (pb_press),
    .release_pulse     (pb_release)
  ); // R3

  // ---------------------------------------------
  // Wake-up event queue
  // ---------------------------------------------
  reg [`EV_WIDTH-1:0]   queue [0:`QUEUE_DEPTH-1];
  reg [`QPTR_WIDTH-1:0] rd_ptr;
  reg [`QPTR_WIDTH-1:0] wr_ptr;
  reg [`QCNT_WIDTH-1:0] q_count;
  reg                   wake_valid;
  reg [`EV_WIDTH-1:0]   wake_code;
  wire                  do_read;
  wire                  do_write;
  integer               i;

  // One event per cycle, fixed priority
  always @* begin
    wake_valid = 1'b1;
    wake_code  = `EV_POR;
    if (por_event) begin
      wake_code = `EV_POR;
    end else if (pb_press) begin
      wake_code = `EV_PB_PRESS;
    end else if (timer_rise) begin
      wake_code = `EV_TIMER;
    end else if (low_rise) begin
      wake_code = `EV_LOW_SUPPLY;
    end else begin
      wake_valid = 1'b0;
    end
  end

  assign do_read  = status_read & ~in_reset & (q_count != 3'h0);
  assign do_write = wake_valid & ~in_reset &
                    ((q_count != `QUEUE_DEPTH) | do_read);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ptr  <= 2'h0;
      wr_ptr  <= 2'h0;
      q_count <= 3'h0;
      for (i = 0; i < `QUEUE_DEPTH; i = i + 1) begin
        queue[i] <= 3'h0;
      end
    end else if (in_reset) begin // R8
      rd_ptr  <= 2'h0;
      wr_ptr  <= 2'h0;
      q_count <= 3'h0;
    end else begin
      if (do_write) begin // R10
        queue[wr_ptr] <= wake_code;
        wr_ptr        <= wr_ptr + 2'h1;
      end
      if (do_read) begin // R10
        rd_ptr <= rd_ptr + 2'h1;
      end
      if (do_write && !do_read) begin
        q_count <= q_count + 3'h1;
      end else if (do_read && !do_write) begin
        q_count <= q_count - 3'h1;
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      event_pending <= 1'b0;
      event_code    <= 3'h0;
      status_ack    <= 1'b0;
    end else begin
      event_pending <= (q_count != 3'h0) & ~in_reset;
      event_code    <= queue[rd_ptr];
      status_ack    <= do_read;
    end
  end

  // ---------------------------------------------
  // Oscillator gating
  // ---------------------------------------------
  reg [1:0] state;
  reg [1:0] next_state;
  wire      any_event;

  assign any_event = wake_valid | pb_release |
                     (status_read & ~in_reset); // R5

  always @* begin
    next_state = state;
    case (state)
      `OSC_IDLE: begin
        if (any_event) begin // R4
          next_state = `OSC_RUN;
        end
      end
      `OSC_RUN: begin
        if (q_count >= 3'h2) begin // R6
          next_state = `OSC_WAIT_ACK;
        end else if (!any_event) begin // R4
          next_state = `OSC_IDLE;
        end
      end
      `OSC_WAIT_ACK: begin
        if (do_read) begin // R6
          next_state = `OSC_RUN;
        end
      end
      default: begin
        next_state = `OSC_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= `OSC_RUN;
      osc_enable <= 1'b1;
    end else if (in_reset || sw_reset_cmd) begin // R7
      state      <= `OSC_RUN;
      osc_enable <= 1'b1;
    end else begin
      state      <= next_state;
      osc_enable <= (next_state != `OSC_IDLE) | pb_pressed;
    end
  end
endmodule // wakeup_osc_reset_control

//--- tb/host_model.sv
// Host model issuing commands and status reads
module host_model (
  input  wire         clk,
  input  wire         cmd_ready,
  output logic        cmd_valid,
  output logic [15:0] cmd_word,
  output logic        status_read
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
    status_read = 1'b0;
  end
  task automatic send(input logic [15:0] w, input bit polite);
    int n;
    n = 0;
    while (polite && !cmd_ready && n < 200) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    #2 cmd_valid = 1'b1;
    cmd_word = w;
    @(posedge clk);
    #2 cmd_valid = 1'b0;
    // Released word shows a changed pattern
    cmd_word = ~w;
  endtask
  task automatic read_status();
    @(posedge clk);
    #2 status_read = 1'b1;
    @(posedge clk);
    #2 status_read = 1'b0;
  endtask
endmodule // host_model

//--- tb/tb_top.sv
// Self-checking bench for the wake-up and reset controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, reset_n = 0, button = 0, timer = 0, low = 0;
  wire         cmd_valid, cmd_ready, status_read, osc_enable, status_ack;
  wire         sensitive_reset, in_reset, event_pending;
  wire  [15:0] cmd_word;
  wire  [2:0]  event_code;
  int          n_mismatch = 0, checks = 0, cycles = 0;
  logic [31:0] seed = 32'h0000_0002;
  int          q[$];
  always #10 clk = ~clk;
  host_model host (.clk(clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .status_read(status_read));
  wakeup_osc_reset_control #(.RESET_COUNT(20)) dut (.clk(clk),
    .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .status_read(status_read), .push_button_input(button),
    .timer_expired(timer), .low_supply(low), .cmd_ready(cmd_ready),
    .osc_enable(osc_enable), .sensitive_reset(sensitive_reset),
    .in_reset(in_reset), .event_pending(event_pending),
    .event_code(event_code), .status_ack(status_ack));
  task automatic summarize();
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [3:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic compare_queue();
    check("pending", q.size() > 0, event_pending);
    if (q.size() > 0) check("code", 4'(q[0]), event_code);
    check("osc", q.size() > 1 || button, osc_enable);
  endtask
  task automatic pop();
    logic e;
    e = q.size() > 0;
    host.read_status();
    check("ack", e, status_ack);
    if (e) void'(q.pop_front());
    repeat (4) @(posedge clk);
    compare_queue();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (in_reset && n < 100) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    q.push_back(0);
    compare_queue();
  endtask
  task automatic wake(ref logic s, input int c);
    #2 s = 1'b1;
    repeat (4) @(posedge clk);
    #2 s = 1'b0;
    repeat (4) @(posedge clk);
    if (q.size() < 4) q.push_back(c);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #2 reset_n = 1'b1;
    check("ready", 0, cmd_ready);
    host.send(16'hC202, 0);
    check("busy mode", 1, sensitive_reset);
    wait_idle();
    pop();
    pop();
    host.send(16'hC200, 1);
    check("mode keep", 1, sensitive_reset);
    host.send(16'hC202, 1);
    check("mode normal", 0, sensitive_reset);
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      if (seed[0]) wake(timer, 2);
      else wake(low, 3);
    end
    compare_queue();
    repeat (4) pop();
    #2 button = 1'b1;
    repeat (1100) @(posedge clk);
    q.push_back(1);
    compare_queue();
    #2 button = 1'b0;
    repeat (1100) @(posedge clk);
    compare_queue();
    host.send(16'hFE00, 1);
    check("sw reset", 1, in_reset);
    check("sw mode", 1, sensitive_reset);
    q.delete();
    wait_idle();
    pop();
    summarize();
  end
endmodule // tb_top

//--- tb/wakeup_osc_monitor.sv
// Assertion checker for the wake-up and reset controller
module wakeup_osc_monitor (
  input wire        clk,
  input wire        reset_n,
  input wire        cmd_valid,
  input wire [15:0] cmd_word,
  input wire        status_read,
  input wire        cmd_ready,
  input wire        osc_enable,
  input wire        sensitive_reset,
  input wire        in_reset,
  input wire        event_pending,
  input wire [2:0]  event_code,
  input wire        status_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  wire take = cmd_valid && cmd_ready;
  wire pll  = take && cmd_word[15:8] == 8'hC2;
  sequence sw_cmd;
    take && cmd_word == 16'hFE00;
  endsequence
  sequence por_queued;
    event_pending && event_code == 3'h0;
  endsequence
  ready_mirror_a: assert property (cmd_ready == !in_reset)
    else $error("ready wrong");
  osc_reset_a: assert property (in_reset |-> osc_enable)
    else $error("osc off in reset");
  sw_reset_a: assert property (sw_cmd |=> in_reset && sensitive_reset)
    else $error("soft reset missed");
  normal_mode_a: assert property (pll && cmd_word[1] |=> !sensitive_reset)
    else $error("normal mode missed");
  mode_keep_a: assert property (pll && !cmd_word[1] |=>
    $stable(sensitive_reset)) else $error("mode changed");
  por_event_a: assert property ($fell(in_reset) |-> ##[1:2] por_queued)
    else $error("power-on event missing");
  read_ack_a: assert property (status_read && !$past(status_read)
    && !in_reset && event_pending |=> status_ack) else $error("no ack");
  ack_cause_a: assert property (status_ack |-> $past(status_read))
    else $error("stray ack");
  read_wakes_a: assert property (status_read && !in_reset
    |-> ##[0:2] osc_enable) else $error("osc not started");
endmodule // wakeup_osc_monitor

bind wakeup_osc_reset_control wakeup_osc_monitor mon (
  .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
  .cmd_word(cmd_word), .status_read(status_read), .cmd_ready(cmd_ready),
  .osc_enable(osc_enable), .sensitive_reset(sensitive_reset),
  .in_reset(in_reset), .event_pending(event_pending),
  .event_code(event_code), .status_ack(status_ack)
);
